// ### core/tt_pkg.sv
// shared constants and types for the split translator link
package tt_pkg;
	localparam int CLK_MHZ        = 100;
	localparam int FRAME_US       = 1000;
	localparam int UFRAME_NS      = 125000;
	localparam int IDLE_US        = 250;
	localparam int CLK_NS         = 10;
	localparam int FRAME_CYC      = FRAME_US * CLK_MHZ;
	localparam int UFRAME_CYC     = UFRAME_NS / CLK_NS;
	localparam int IDLE_CYC       = IDLE_US * CLK_MHZ;
	localparam int FS_BIT_PS      = 83333;
	localparam int FS_TOL_BITS    = 3;
	localparam int FS_TOL_CYC     = FS_TOL_BITS * FS_BIT_PS / (CLK_NS * 1000);
	localparam int UFRAMES        = 8;
	localparam int NP_BUFS        = 2;
	localparam int BUDGET_BYTES   = 188;
	localparam int RAW_TENTHS     = 1875;
	localparam int MAX_PERIODIC   = 1157;
	localparam int THINK_LSB      = 5;
	localparam int EP_W           = 7;
	localparam int FRAME_W        = 11;
	localparam logic [1:0] THINK_DEF = 2'h0;
	localparam logic [1:0] ST_ACK   = 2'h0;
	localparam logic [1:0] ST_NAK   = 2'h1;
	localparam logic [1:0] ST_STALL = 2'h2;
	typedef enum logic [1:0] {
		CS_NYET  = 2'b00,
		CS_DONE  = 2'b01,
		CS_STALL = 2'b10
	} cs_code_t;
	typedef enum logic [2:0] {
		BUF_FREE  = 3'b000,
		BUF_PEND  = 3'b001,
		BUF_READY = 3'b010,
		BUF_BUSY  = 3'b011,
		BUF_OLD   = 3'b100
	} buf_state_t;
endpackage

// ### core/tt_link_if.sv
// link between the high-speed host end and the translator end
`timescale 1ns/1ps
`default_nettype none
interface tt_link_if;
	import tt_pkg::*;
	logic                  ss_valid;
	logic [EP_W-1:0]       ss_ep;
	logic                  ss_ready;
	logic                  ss_resp_valid;
	logic                  ss_resp_ack;
	logic                  cs_valid;
	logic [EP_W-1:0]       cs_ep;
	logic                  cs_resp_valid;
	cs_code_t              cs_resp_code;
	logic [1:0]            cs_resp_status;
	logic                  clr_valid;
	logic [EP_W-1:0]       clr_ep;
	logic                  sof_valid;
	logic [FRAME_W-1:0]    sof_frame;
	logic                  hs_active;
	logic [15:0]           hub_chars;
	modport host (output ss_valid, ss_ep, cs_valid, cs_ep, clr_valid, clr_ep,
		sof_valid, sof_frame, hs_active,
		input ss_ready, ss_resp_valid, ss_resp_ack, cs_resp_valid, cs_resp_code,
		cs_resp_status, hub_chars);
	modport tt (input ss_valid, ss_ep, cs_valid, cs_ep, clr_valid, clr_ep,
		sof_valid, sof_frame, hs_active,
		output ss_ready, ss_resp_valid, ss_resp_ack, cs_resp_valid, cs_resp_code,
		cs_resp_status, hub_chars);
endinterface
`default_nettype wire

// ### core/tt_end.sv
// translator end: non-periodic buffers, downstream queue and full-speed frame timer
// Overview of operation
// - at least two non-periodic transaction buffers
// - buffer count may exceed two
// - failed busy buffer never reallocated until cleared
// - host clears busy buffer on endpoint halt
// - eight microframes per frame, restart at zero
// - host budgets 188 bytes per microframe
// - host caps periodic traffic at 1157 bytes
// - start-split one microframe early, complete-splits after
// - budget uses max payload, gaps, think time
// - think time reported in hub characteristics bits 5-6
// - own frame timer locked to microframe SOFs
// - frame-number change marks microframe zero
// - stop downstream SOFs after 250 us idle
// - downstream SOF within three bit times
// - microframe holds at most 187.5 raw bytes
// - host keeps bulk/control out of periodic pipeline
// - answered complete-split moves buffer ready to old
`timescale 1ns/1ps
`default_nettype none
module tt_end #(
	parameter int         NBUF      = tt_pkg::NP_BUFS,
	parameter int         DEPTH     = 2,
	parameter int         FRAME_CYC = tt_pkg::FRAME_CYC,
	parameter int         IDLE_CYC  = tt_pkg::IDLE_CYC,
	parameter logic [1:0] THINK     = tt_pkg::THINK_DEF
) (
	input  wire logic                         clk,
	input  wire logic                         reset,
	tt_link_if.tt                             link,
	output logic                              ds_valid,
	output logic [tt_pkg::EP_W-1:0]           ds_ep,
	output logic [$clog2(NBUF)-1:0]           ds_buf,
	input  wire logic                         ds_ready,
	input  wire logic                         ds_done,
	input  wire logic [$clog2(NBUF)-1:0]      ds_done_buf,
	input  wire logic [1:0]                   ds_done_status,
	input  wire logic                         ds_done_fail,
	output logic                              fs_sof,
	output logic [tt_pkg::FRAME_W-1:0]        fs_frame,
	output logic [2:0]                        uframe,
	output logic                              sof_stopped
);
	import tt_pkg::*;
	localparam int BW = $clog2(NBUF);
	localparam int PW = $clog2(DEPTH);
	localparam int TW = $clog2(FRAME_CYC);
	localparam int IW = $clog2(IDLE_CYC + 1);

	initial begin
		if (NBUF < 2) $error("tt_end needs at least two non-periodic buffers");
		if (DEPTH != 2) $error("tt_end queue depth must be two");
		if (FRAME_CYC < 2 || IDLE_CYC < 2) $error("tt_end counts too small");
	end

	buf_state_t          st_q   [NBUF];
	logic [EP_W-1:0]     bep_q  [NBUF];
	logic [1:0]          bsta_q [NBUF];

	// buffer search: first reusable buffer, buffer owned by endpoint
	logic                free_hit;
	logic [BW-1:0]       free_idx;
	logic                cs_hit;
	logic [BW-1:0]       cs_idx;
	logic                clr_hit;
	logic [BW-1:0]       clr_idx;
	always_comb begin
		free_hit = 1'b0;
		free_idx = '0;
		cs_hit   = 1'b0;
		cs_idx   = '0;
		clr_hit  = 1'b0;
		clr_idx  = '0;
		for (int i = NBUF - 1; i >= 0; i--) begin
			if (st_q[i] == BUF_FREE || st_q[i] == BUF_OLD) begin
				free_hit = 1'b1;
				free_idx = BW'(i);
			end
			if (st_q[i] != BUF_FREE && bep_q[i] == link.cs_ep) begin
				cs_hit = 1'b1;
				cs_idx = BW'(i);
			end
			if (st_q[i] != BUF_FREE && bep_q[i] == link.clr_ep) begin
				clr_hit = 1'b1;
				clr_idx = BW'(i);
			end
		end
	end

	// two-entry queue of allocated start-splits toward the downstream handler
	logic [EP_W-1:0]     qep_q  [DEPTH];
	logic [BW-1:0]       qbuf_q [DEPTH];
	logic [PW-1:0]       wr_q;
	logic [PW-1:0]       rd_q;
	logic [PW:0]         cnt_q;
	logic                ss_ready_q;
	logic                ds_valid_q;
	wire                 ss_take = link.ss_valid && ss_ready_q;
	wire                 alloc   = ss_take && free_hit;
	wire                 ds_take = ds_valid_q && ds_ready;
	wire  [PW:0]         cnt_d   = cnt_q + {{PW{1'b0}}, alloc} - {{PW{1'b0}}, ds_take};

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_q       <= '0;
			rd_q       <= '0;
			cnt_q      <= '0;
			ss_ready_q <= 1'b0;
			ds_valid_q <= 1'b0;
		end else begin
			if (alloc) wr_q <= wr_q + 1'b1;
			if (ds_take) rd_q <= rd_q + 1'b1;
			cnt_q      <= cnt_d;
			ss_ready_q <= cnt_d != (PW + 1)'(DEPTH);
			ds_valid_q <= cnt_d != '0;
		end
	end
	always_ff @(posedge clk) begin
		if (alloc) begin
			qep_q[wr_q]  <= link.ss_ep;
			qbuf_q[wr_q] <= free_idx;
		end
	end
	assign ds_valid = ds_valid_q;
	assign ds_ep    = qep_q[rd_q];
	assign ds_buf   = qbuf_q[rd_q];

	// buffer state per slot; a clear outranks every other event
	always_ff @(posedge clk) begin
		for (int i = 0; i < NBUF; i++) begin
			if (reset) begin
				st_q[i]   <= BUF_FREE;
				bep_q[i]  <= '0;
				bsta_q[i] <= ST_ACK;
			end else if (link.clr_valid && clr_hit && clr_idx == BW'(i)) begin
				st_q[i] <= BUF_FREE;
			end else if (alloc && free_idx == BW'(i)) begin
				st_q[i]  <= BUF_PEND;
				bep_q[i] <= link.ss_ep;
			end else if (ds_done && ds_done_buf == BW'(i) && st_q[i] == BUF_PEND) begin
				st_q[i]   <= ds_done_fail ? BUF_BUSY : BUF_READY;
				bsta_q[i] <= ds_done_status;
			end else if (link.cs_valid && cs_hit && cs_idx == BW'(i)
				&& st_q[i] == BUF_READY) begin
				st_q[i] <= BUF_OLD;
			end
		end
	end

	// split answers one cycle after the request
	logic                ss_resp_valid_q;
	logic                ss_resp_ack_q;
	logic                cs_resp_valid_q;
	cs_code_t            cs_resp_code_q;
	logic [1:0]          cs_resp_status_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			ss_resp_valid_q  <= 1'b0;
			ss_resp_ack_q    <= 1'b0;
			cs_resp_valid_q  <= 1'b0;
			cs_resp_code_q   <= CS_NYET;
			cs_resp_status_q <= ST_ACK;
		end else begin
			ss_resp_valid_q <= ss_take;
			ss_resp_ack_q   <= alloc;
			cs_resp_valid_q <= link.cs_valid;
			if (link.cs_valid) begin
				cs_resp_status_q <= bsta_q[cs_idx];
				if (!cs_hit) cs_resp_code_q <= CS_STALL;
				else if (st_q[cs_idx] == BUF_PEND) cs_resp_code_q <= CS_NYET;
				else cs_resp_code_q <= CS_DONE;
			end
		end
	end
	assign link.ss_ready       = ss_ready_q;
	assign link.ss_resp_valid  = ss_resp_valid_q;
	assign link.ss_resp_ack    = ss_resp_ack_q;
	assign link.cs_resp_valid  = cs_resp_valid_q;
	assign link.cs_resp_code   = cs_resp_code_q;
	assign link.cs_resp_status = cs_resp_status_q;

	logic [15:0]         hub_chars_q;
	always_ff @(posedge clk) begin
		if (reset) hub_chars_q <= '0;
		else hub_chars_q <= 16'(THINK) << THINK_LSB;
	end
	assign link.hub_chars = hub_chars_q;

	// frame timer locked to the microframe-zero SOF
	logic [FRAME_W-1:0]  last_frame_q;
	logic                seen_q;
	logic [TW-1:0]       timer_q;
	logic [IW-1:0]       idle_q;
	logic                stopped_q;
	logic                fs_sof_q;
	logic [FRAME_W-1:0]  fs_frame_q;
	logic [2:0]          uframe_q;
	wire                 new_frame = link.sof_valid
		&& (!seen_q || link.sof_frame != last_frame_q);
	wire                 wrap      = timer_q == TW'(FRAME_CYC - 1);
	wire                 idle_end  = idle_q == IW'(IDLE_CYC - 1);
	wire                 stopped_d = new_frame ? 1'b0 : (stopped_q || idle_end);

	always_ff @(posedge clk) begin
		if (reset) begin
			last_frame_q <= '0;
			seen_q       <= 1'b0;
			timer_q      <= '0;
			idle_q       <= '0;
			stopped_q    <= 1'b1;
			fs_sof_q     <= 1'b0;
			fs_frame_q   <= '0;
			uframe_q     <= '0;
		end else begin
			if (link.sof_valid) begin
				last_frame_q <= link.sof_frame;
				seen_q       <= 1'b1;
			end
			timer_q <= (new_frame || wrap) ? '0 : timer_q + 1'b1;
			if (link.hs_active || link.sof_valid) idle_q <= '0;
			else if (!idle_end) idle_q <= idle_q + 1'b1;
			stopped_q <= stopped_d;
			fs_sof_q  <= !stopped_d && (new_frame || wrap);
			if (new_frame) fs_frame_q <= link.sof_frame;
			else if (wrap) fs_frame_q <= fs_frame_q + 1'b1;
			if (new_frame) uframe_q <= '0;
			else if (link.sof_valid) uframe_q <= uframe_q + 1'b1;
		end
	end
	assign fs_sof      = fs_sof_q;
	assign fs_frame    = fs_frame_q;
	assign uframe      = uframe_q;
	assign sof_stopped = stopped_q;
endmodule
`default_nettype wire

// ### core/tt_host_end.sv
// host end: microframe SOFs, non-periodic split sequencing and best-case budget
`timescale 1ns/1ps
`default_nettype none
module tt_host_end #(
	parameter int UFRAME_CYC = tt_pkg::UFRAME_CYC
) (
	input  wire logic                         clk,
	input  wire logic                         reset,
	tt_link_if.host                           link,
	input  wire logic                         hs_quiet,
	output logic [2:0]                        uframe,
	output logic [tt_pkg::FRAME_W-1:0]        frame,
	input  wire logic                         np_valid,
	input  wire logic [tt_pkg::EP_W-1:0]      np_ep,
	output logic                              np_ready,
	output logic                              np_done,
	output logic [1:0]                        np_result,
	input  wire logic                         halt_valid,
	input  wire logic [tt_pkg::EP_W-1:0]      halt_ep,
	input  wire logic                         bud_clear,
	input  wire logic                         bud_valid,
	input  wire logic [10:0]                  bud_payload,
	input  wire logic [7:0]                   bud_overhead,
	output logic                              bud_done,
	output logic                              bud_ok,
	output logic [2:0]                        bud_ss_uf,
	output logic [7:0]                        bud_occ_mask,
	output logic [7:0]                        bud_cs_mask
);
	import tt_pkg::*;
	localparam int UW = $clog2(UFRAME_CYC);

	initial begin
		if (UFRAME_CYC < 2) $error("tt_host_end microframe count too small");
		if (BUDGET_BYTES * 10 < RAW_TENTHS) $error("budget below raw microframe size");
	end

	// microframe SOF source; frame number steps at microframe zero
	logic [UW-1:0]       ucnt_q;
	logic                sof_q;
	logic                act_q;
	logic [2:0]          uframe_q;
	logic [FRAME_W-1:0]  frame_q;
	wire                 utick = ucnt_q == UW'(UFRAME_CYC - 1);
	always_ff @(posedge clk) begin
		if (reset) begin
			ucnt_q   <= '0;
			sof_q    <= 1'b0;
			act_q    <= 1'b0;
			uframe_q <= 3'h7;
			frame_q  <= '0;
		end else begin
			ucnt_q <= utick ? '0 : ucnt_q + 1'b1;
			act_q  <= !hs_quiet;
			sof_q  <= utick && !hs_quiet;
			if (utick && !hs_quiet) begin
				uframe_q <= uframe_q + 1'b1;
				if (uframe_q == 3'h7) frame_q <= frame_q + 1'b1;
			end
		end
	end
	assign link.sof_valid = sof_q;
	assign link.sof_frame = frame_q;
	assign link.hs_active = act_q;
	assign uframe         = uframe_q;
	assign frame          = frame_q;

	// non-periodic split sequencer, bulk/control only
	typedef enum logic [1:0] {
		NP_IDLE = 2'b00,
		NP_SS   = 2'b01,
		NP_SSW  = 2'b10,
		NP_CSW  = 2'b11
	} np_state_t;
	np_state_t           np_q;
	logic [EP_W-1:0]     ep_q;
	logic                ss_v_q;
	logic                cs_v_q;
	logic                done_q;
	logic [1:0]          res_q;
	logic                ready_q;
	logic                clr_q;
	logic [EP_W-1:0]     clr_ep_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			np_q    <= NP_IDLE;
			ep_q    <= '0;
			ss_v_q  <= 1'b0;
			cs_v_q  <= 1'b0;
			done_q  <= 1'b0;
			res_q   <= ST_ACK;
			ready_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			cs_v_q <= 1'b0;
			case (np_q)
				NP_IDLE: begin
					ready_q <= 1'b1;
					if (np_valid && ready_q) begin
						ep_q    <= np_ep;
						ss_v_q  <= 1'b1;
						ready_q <= 1'b0;
						np_q    <= NP_SS;
					end
				end
				NP_SS: begin
					if (link.ss_ready) begin
						ss_v_q <= 1'b0;
						np_q   <= NP_SSW;
					end
				end
				NP_SSW: begin
					if (link.ss_resp_valid) begin
						if (link.ss_resp_ack) begin
							cs_v_q <= 1'b1;
							np_q   <= NP_CSW;
						end else begin
							res_q  <= ST_NAK;
							done_q <= 1'b1;
							np_q   <= NP_IDLE;
						end
					end
				end
				NP_CSW: begin
					if (link.cs_resp_valid) begin
						if (link.cs_resp_code == CS_NYET) begin
							cs_v_q <= 1'b1;
						end else begin
							res_q  <= (link.cs_resp_code == CS_STALL) ? ST_STALL
								: link.cs_resp_status;
							done_q <= 1'b1;
							np_q   <= NP_IDLE;
						end
					end
				end
				default: np_q <= NP_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			clr_q    <= 1'b0;
			clr_ep_q <= '0;
		end else begin
			clr_q <= halt_valid;
			if (halt_valid) clr_ep_q <= halt_ep;
		end
	end
	assign link.ss_valid  = ss_v_q;
	assign link.ss_ep     = ep_q;
	assign link.cs_valid  = cs_v_q;
	assign link.cs_ep     = ep_q;
	assign link.clr_valid = clr_q;
	assign link.clr_ep    = clr_ep_q;
	assign np_ready       = ready_q;
	assign np_done        = done_q;
	assign np_result      = res_q;

	// best-case budget: 188 bytes per microframe, no stuffing
	logic [11:0]         tot_q;
	logic                bd_q;
	logic                ok_q;
	logic [2:0]          ssuf_q;
	logic [7:0]          occ_q;
	logic [7:0]          csm_q;
	wire  [11:0]         think_b = {10'h000, link.hub_chars[THINK_LSB+1:THINK_LSB]} + 12'h001;
	wire  [11:0]         cost    = {1'b0, bud_payload} + {4'h0, bud_overhead} + think_b;
	wire  [11:0]         end_b   = tot_q + cost - 12'h001;
	wire  [11:0]         s_uf    = tot_q / 12'(BUDGET_BYTES);
	wire  [11:0]         e_uf    = end_b / 12'(BUDGET_BYTES);
	wire                 fits    = (tot_q + cost) <= 12'(MAX_PERIODIC);
	logic [7:0]          occ_d;
	logic [7:0]          csm_d;
	always_comb begin
		occ_d = '0;
		csm_d = '0;
		for (int k = 0; k < UFRAMES; k++) begin
			if (12'(k) >= s_uf && 12'(k) <= e_uf) occ_d[k] = 1'b1;
			if (12'(k) > s_uf && 12'(k) <= e_uf + 12'h002) csm_d[k] = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset || bud_clear) begin
			tot_q  <= '0;
			bd_q   <= 1'b0;
			ok_q   <= 1'b0;
			ssuf_q <= '0;
			occ_q  <= '0;
			csm_q  <= '0;
		end else begin
			bd_q <= bud_valid;
			if (bud_valid) begin
				ok_q   <= fits;
				ssuf_q <= s_uf[2:0] - 3'h1;
				occ_q  <= fits ? occ_d : 8'h00;
				csm_q  <= fits ? csm_d : 8'h00;
				if (fits) tot_q <= tot_q + cost;
			end
		end
	end
	assign bud_done     = bd_q;
	assign bud_ok       = ok_q;
	assign bud_ss_uf    = ssuf_q;
	assign bud_occ_mask = occ_q;
	assign bud_cs_mask  = csm_q;
endmodule
`default_nettype wire

// ### verif/tt_link_sva.sv
// link checker: answers, polling, think-time field and microframe count
`timescale 1ns/1ps
`default_nettype none
module tt_link_sva #(
	parameter logic [1:0] THINK = tt_pkg::THINK_DEF
) (
	input wire logic                       clk,
	input wire logic                       reset,
	input wire logic                       ss_valid,
	input wire logic                       ss_ready,
	input wire logic                       ss_resp_valid,
	input wire logic                       ss_resp_ack,
	input wire logic                       cs_valid,
	input wire logic                       cs_resp_valid,
	input wire tt_pkg::cs_code_t           cs_resp_code,
	input wire logic                       clr_valid,
	input wire logic                       sof_valid,
	input wire logic [tt_pkg::FRAME_W-1:0] sof_frame,
	input wire logic [15:0]                hub_chars
);
	import tt_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic               seen_q;
	logic [3:0]         n_sof_q;
	logic [FRAME_W-1:0] fr_q;
	wire new_fr = sof_valid && (!seen_q || sof_frame != fr_q);
	// sofs seen since the last frame-number change
	always_ff @(posedge clk) begin
		if (reset) begin
			seen_q <= 1'b0;
			n_sof_q <= 4'h0;
		end else if (sof_valid) begin
			seen_q <= 1'b1;
			fr_q <= sof_frame;
			n_sof_q <= new_fr ? 4'h0 : n_sof_q + 4'h1;
		end
	end
	sequence s_ss_take;
		ss_valid && ss_ready;
	endsequence
	sequence s_nyet;
		cs_resp_valid && cs_resp_code == CS_NYET;
	endsequence
	a_ss_answer: assert property (s_ss_take |=> ss_resp_valid)
		else $error("start-split taken but not answered next cycle");
	a_ss_cause: assert property (ss_resp_valid |-> $past(ss_valid && ss_ready))
		else $error("start-split answer without a taken request");
	a_cs_answer: assert property (cs_valid |=> cs_resp_valid)
		else $error("complete-split not answered next cycle");
	a_cs_cause: assert property (cs_resp_valid |-> $past(cs_valid))
		else $error("complete-split answer without a request");
	a_ack_then_poll: assert property (s_ss_take ##1 ss_resp_ack |-> ##[1:8] cs_valid)
		else $error("no complete-split after an accepted start-split");
	a_nyet_repoll: assert property (s_nyet |-> ##[1:8] cs_valid)
		else $error("no repoll after a not-yet answer");
	a_think_field: assert property (!$past(reset) |-> hub_chars == {9'h0, THINK, 5'h0})
		else $error("think time field wrong");
	a_frame_eight: assert property (sof_valid && seen_q && !new_fr |-> n_sof_q < 4'h7)
		else $error("more than eight microframes in one frame");
	a_clr_pulse: assert property (clr_valid |=> !clr_valid)
		else $error("clear request longer than one cycle");
endmodule
`default_nettype wire

// ### verif/split_translator_frame_pipeline_tb.sv
// bench: host end and translator end joined by the link
`timescale 1ns/1ps
`default_nettype none
module split_translator_frame_pipeline_tb;
	import tt_pkg::*;
	localparam logic [1:0] THK = 2'h2;
	logic clk = 1'b0, reset = 1'b1, hs_quiet = 1'b0;
	logic np_valid = 1'b0, halt_valid = 1'b0, bud_clear = 1'b0, bud_valid = 1'b0;
	logic [EP_W-1:0] np_ep = '0, halt_ep = '0;
	logic [10:0] bud_payload = '0;
	logic [7:0] bud_overhead = '0;
	logic ds_ready = 1'b0, ds_done = 1'b0, ds_done_buf = 1'b0, ds_done_fail = 1'b0;
	logic [1:0] ds_done_status = '0;
	logic np_ready, np_done, bud_done, bud_ok, ds_valid, ds_buf, fs_sof, sof_stopped;
	logic [1:0] np_result;
	logic [2:0] bud_ss_uf, uframe, uf_e, h_uframe;
	logic [7:0] bud_occ_mask, bud_cs_mask;
	logic [EP_W-1:0] ds_ep;
	logic [FRAME_W-1:0] last_fr, fs_frame, h_frame;
	logic exp_fs = 1'b0, exp_uf = 1'b0, seen = 1'b0;
	int error_cnt = 0, total_checks = 0, cyc = 0, tot = 0, n;
	tt_link_if link ();
	tt_end #(.FRAME_CYC(200), .IDLE_CYC(100), .THINK(THK)) tt_end_i (.clk(clk),
		.reset(reset), .link(link), .ds_valid(ds_valid), .ds_ep(ds_ep), .ds_buf(ds_buf),
		.ds_ready(ds_ready), .ds_done(ds_done), .ds_done_buf(ds_done_buf),
		.ds_done_status(ds_done_status), .ds_done_fail(ds_done_fail), .fs_sof(fs_sof),
		.fs_frame(fs_frame), .uframe(uframe), .sof_stopped(sof_stopped));
	tt_host_end #(.UFRAME_CYC(25)) tt_host_end_i (.clk(clk), .reset(reset), .link(link),
		.hs_quiet(hs_quiet), .uframe(h_uframe), .frame(h_frame),
		.np_valid(np_valid), .np_ep(np_ep),
		.np_ready(np_ready), .np_done(np_done), .np_result(np_result),
		.halt_valid(halt_valid), .halt_ep(halt_ep), .bud_clear(bud_clear),
		.bud_valid(bud_valid), .bud_payload(bud_payload), .bud_overhead(bud_overhead),
		.bud_done(bud_done), .bud_ok(bud_ok), .bud_ss_uf(bud_ss_uf),
		.bud_occ_mask(bud_occ_mask), .bud_cs_mask(bud_cs_mask));
	tt_link_sva #(.THINK(THK)) tt_link_sva_i (.clk(clk), .reset(reset),
		.ss_valid(link.ss_valid), .ss_ready(link.ss_ready),
		.ss_resp_valid(link.ss_resp_valid), .ss_resp_ack(link.ss_resp_ack),
		.cs_valid(link.cs_valid), .cs_resp_valid(link.cs_resp_valid),
		.cs_resp_code(link.cs_resp_code), .clr_valid(link.clr_valid),
		.sof_valid(link.sof_valid), .sof_frame(link.sof_frame), .hub_chars(link.hub_chars));
	always #5 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// downstream sof follows each frame-number change, and microframe index each high-speed sof, by one cycle
	always @(posedge clk) begin
		if (exp_fs) chk(16'(fs_sof), 16'h1);
		if (exp_fs) chk(16'(fs_frame), 16'(last_fr));
		if (exp_uf) chk(16'(uframe), 16'(uf_e));
		exp_fs = 1'b0;
		exp_uf = 1'b0;
		if (reset) seen = 1'b0;
		else if (link.sof_valid) begin
			exp_uf = 1'b1;
			exp_fs = !seen || link.sof_frame !== last_fr;
			if (exp_fs && seen) chk(16'(h_frame), 16'(last_fr + 11'h1));
			uf_e = exp_fs ? 3'h0 : uf_e + 3'h1;
			chk(16'(h_uframe), 16'(uf_e));
			last_fr = link.sof_frame;
			seen = 1'b1;
		end
	end
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wt(ref logic s);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (s !== 1'b1 && n < 400);
		chk(16'(s), 16'h1);
		#1;
	endtask
	// one non-periodic split; the far side stalls before taking and finishing it
	// hlt clears the buffer while the split is still pending, so the poll is stalled
	task automatic xfer(input logic [6:0] ep, input logic fail, input logic [1:0] st,
		input logic ack, input logic eb, input logic hlt);
		np_ep = ep;
		np_valid = 1'b1;
		wt(np_ready);
		np_valid = 1'b0;
		if (ack) begin
			wt(ds_valid);
			repeat (3) step();
			ds_ready = 1'b1;
			ds_done_buf = ds_buf;
			chk(16'(ds_ep), 16'(ep));
			chk(16'(ds_buf), 16'(eb));
			step();
			ds_ready = 1'b0;
			if (hlt) begin
				halt_ep = ep;
				halt_valid = 1'b1;
				step();
				halt_valid = 1'b0;
			end else begin
				repeat (4) step();
				ds_done = 1'b1;
				ds_done_status = st;
				ds_done_fail = fail;
				step();
				ds_done = 1'b0;
			end
		end
		wt(np_done);
		chk(16'(np_result), ack ? 16'(st) : 16'(ST_NAK));
	endtask
	task automatic bud(input logic [10:0] p, input logic [7:0] o);
		int c, s, e;
		c = p + o + THK + 1;
		s = tot / 188;
		e = (tot + c - 1) / 188;
		bud_payload = p;
		bud_overhead = o;
		bud_valid = 1'b1;
		step();
		bud_valid = 1'b0;
		chk(16'(bud_done), 16'h1);
		chk(16'(bud_ok), 16'(tot + c <= 1157));
		if (tot + c <= 1157) begin
			chk(16'(bud_ss_uf), 16'((s + 7) % 8));
			chk(16'(bud_occ_mask), 16'(((1 << (e + 1)) - (1 << s)) & 255));
			chk(16'(bud_cs_mask), 16'(((1 << (e + 3)) - (1 << (s + 1))) & 255));
			tot += c;
		end
		step();
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1;
		chk(link.hub_chars, 16'h0);
		chk(16'({link.ss_ready, ds_valid, sof_stopped}), 16'h1);
		reset = 1'b0;
		repeat (2) step();
		chk(link.hub_chars, 16'h0040);
		repeat (450) step();
		chk(16'(sof_stopped), 16'h0);
		bud_clear = 1'b1;
		step();
		bud_clear = 1'b0;
		bud(11'd64, 8'd8);
		bud(11'd300, 8'd10);
		bud(11'd700, 8'd20);
		bud(11'd40, 8'd3);
		bud(11'd0, 8'd0);
		xfer(7'h01, 1'b0, ST_ACK, 1'b1, 1'b0, 1'b0);
		xfer(7'h01, 1'b0, ST_NAK, 1'b1, 1'b0, 1'b0);
		xfer(7'h02, 1'b1, ST_STALL, 1'b1, 1'b0, 1'b0);
		xfer(7'h03, 1'b1, ST_ACK, 1'b1, 1'b1, 1'b0);
		xfer(7'h04, 1'b0, ST_ACK, 1'b0, 1'b0, 1'b0);
		halt_ep = 7'h02;
		halt_valid = 1'b1;
		step();
		halt_valid = 1'b0;
		repeat (4) step();
		xfer(7'h04, 1'b0, ST_ACK, 1'b1, 1'b0, 1'b0);
		xfer(7'h05, 1'b0, ST_STALL, 1'b1, 1'b0, 1'b1);
		chk(16'({bud_done, bud_ok, bud_occ_mask}), 16'h0);
		hs_quiet = 1'b1;
		repeat (90) step();
		chk(16'(sof_stopped), 16'h0);
		repeat (60) step();
		chk(16'(sof_stopped), 16'h1);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			if (fs_sof !== 1'b0) n++;
		end
		#1;
		chk(16'(n), 16'h0);
		hs_quiet = 1'b0;
		wt(fs_sof);
		chk(16'(sof_stopped), 16'h0);
		repeat (250) step();
		close_out();
	end
endmodule
`default_nettype wire
